// ==== tb_timer1_event_flags_and_masks.sv ====
`timescale 1ns/1ns
module tb_timer1_event_flags_and_masks;
  logic        clk_i = 1'b0;
  logic        rst_i = 1'b1;
  logic [6:0]  addr;
  logic        sp, wr, rd, ge, hit;
  logic [7:0]  wd, rdata, temp, low_o, high_o;
  logic [3:0]  ack, mode, irq;
  logic [9:0]  ev = '0;
  logic [15:0] sample = '0;
  logic [6:0]  offs [4] = '{7'h27, 7'h38, 7'h39, 7'h3a};
  int          fails = 0, n_tests = 0, cycles = 0, seed = 783, r;
  int          flags, mask, pa, pb, lo, hi;
  initial {temp, mode} = '0;
  tef_cpu_model cpu (.clk_i(clk_i), .io_addr_o(addr), .io_space_o(sp), .io_wr_o(wr), .io_rd_o(rd),
    .io_wdata_o(wd), .global_en_o(ge), .vector_ack_o(ack));
  tef_timer_event_flags DUT (.clk_i(clk_i), .rst_i(rst_i), .io_addr_i(addr), .io_space_i(sp),
    .io_wr_i(wr), .io_rd_i(rd), .io_wdata_i(wd), .io_rdata_o(rdata), .io_hit_o(hit),
    .global_irq_en_i(ge), .waveform_mode_select_i(mode), .capture_evt_i(ev[0]), .top_evt_i(ev[1]),
    .match_a_i(ev[2]), .match_b_i(ev[3]), .force_compare_a_i(ev[4]), .force_compare_b_i(ev[5]),
    .overflow_evt_i(ev[6]), .mode_tov_evt_i(ev[7]), .capture_load_i(ev[8]),
    .capture_sample_i(sample), .low_byte_rd_i(ev[9]), .shared_temp_i(temp), .vector_ack_i(ack),
    .irq_req_o(irq), .capture_value_low_o(low_o), .temp_load_o(high_o));
  always #20 clk_i = ~clk_i;
  function automatic int eff(input logic s, input logic [6:0] a);
    return s ? int'(a) : int'(a) - 32;
  endfunction : eff
  task automatic check(input logic [15:0] seen, input logic [15:0] exp);
    n_tests++;
    if (seen !== exp) begin
      fails++;
      $display("[FAIL] t=%0t seen=%h expected=%h", $time, seen, exp);
    end
  endtask : check
  task automatic tally_and_finish();
    $display("comparisons %0d mismatches %0d", n_tests, fails);
    if (fails == 0 && n_tests > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask : tally_and_finish
  // Reference model; the match delay stage is why compare flags land one edge later
  always @(posedge clk_i) begin : model
    int e, st, cl;
    logic ct, on;
    e  = eff(sp, addr);
    ct = mode inside {4'h8, 4'ha, 4'hc, 4'he};
    on = mode inside {4'h0, 4'h4, 4'hc};
    st = ((ct ? ev[1] : ev[0]) << 5) | (pa << 4) | (pb << 3) | ((on ? ev[6] : ev[7]) << 2);
    cl = ((wr && e == 'h38) ? int'(wd) : 0) | (int'(ack) << 2);
    if (rst_i) begin
      {flags, mask, pa, pb, lo, hi} = '0;
    end else begin
      flags = ((flags & ~cl) | st) & 'h3c;
      if (wr && e == 'h39) mask = wd & 'h3c;
      pa = ev[2];
      pb = ev[3];
      if (ev[8] && !ct) begin
        lo = sample[7:0];
        hi = sample[15:8];
      end else if (wr && e == 'h27) begin
        hi = wd;
      end
    end
  end
  // Outputs are settled by the falling edge
  always @(negedge clk_i) begin : mon
    int e;
    e = eff(sp, addr);
    if (!rst_i) begin
      if (rd) check(rdata, e == 'h27 ? temp : e == 'h38 ? flags : e == 'h39 ? mask : 0);
      if (rd) check(hit, e inside {'h27, 'h38, 'h39});
      check(irq, ge ? (flags & mask) >> 2 : 0);
      check({high_o, low_o}, {hi[7:0], lo[7:0]});
    end
  end
  // Hang guard
  always @(posedge clk_i) begin
    cycles++;
    if (cycles == 6000) begin
      fails++;
      tally_and_finish();
    end
  end
  // Reset, then a walk of the map in both spaces, then random traffic
  initial begin
    repeat (16) @(posedge clk_i);
    #1 rst_i = 1'b0;
    for (int i = 0; i < 8; i++) cpu.step(offs[i % 4], i[2], 1'b0, 8'h00, 1'b1, 4'h0);
    $display("test reset_map done");
    repeat (3000) begin
      r = $random(seed);
      cpu.step(offs[r[1:0]], r[6], r[2] & r[3], r[15:8], r[4] | r[5],
               r[19:16] & r[23:20] & r[27:24]);
      ev     = $random(seed) & $random(seed);
      mode   = $random(seed);
      sample = $random(seed);
      temp   = $random(seed);
    end
    $display("test random_traffic done");
    // Second reset in mid-run with the pulses quiet, then read the map back
    ev    = '0;
    rst_i = 1'b1;
    for (int i = 0; i < 8; i++) begin
      if (i == 2) rst_i = 1'b0;
      cpu.step(offs[i % 4], i[0], 1'b0, 8'h00, 1'b1, 4'h0);
    end
    $display("test mid_reset done");
    tally_and_finish();
  end
endmodule : tb_timer1_event_flags_and_masks

// ==== tef_cpu_model.sv ====
`timescale 1ns/1ns
// CPU side of the I/O bus: one access per clock, launched 1 ns after the edge
module tef_cpu_model (
  input  wire logic       clk_i,        // I/O clock
  output logic      [6:0] io_addr_o,    // Address
  output logic            io_space_o,   // 1: I/O offset
  output logic            io_wr_o,      // Write strobe
  output logic            io_rd_o,      // Read strobe
  output logic      [7:0] io_wdata_o,   // Write data
  output logic            global_en_o,  // Global enable
  output logic      [3:0] vector_ack_o  // Vector executed
);
  // Idle bus at time zero so no strobe starts unknown
  initial begin
    {io_addr_o, io_space_o, io_wr_o, io_rd_o, io_wdata_o, global_en_o, vector_ack_o} = '0;
  end
  // A read is posted whenever no write is, so read data is checked in every cycle without a write
  task automatic step(input logic [6:0] off, input logic sp, input logic wr, input logic [7:0] d,
                      input logic ge, input logic [3:0] ack);
    @(posedge clk_i);
    #1;
    io_addr_o    = sp ? off : off + 7'h20;
    io_space_o   = sp;
    io_wr_o      = wr;
    io_rd_o      = ~wr;
    io_wdata_o   = d;
    global_en_o  = ge;
    vector_ack_o = ack;
  endtask : step
endmodule : tef_cpu_model

// ==== tef_pkg.sv ====
package tef_pkg;

  // ----------------------------------------------------------------
  // Register map
  // ----------------------------------------------------------------
  localparam logic [6:0] IO_CAPTURE_VALUE_HIGH = 7'h27;
  localparam logic [6:0] IO_TIMER_EVENT_FLAGS  = 7'h38;
  localparam logic [6:0] IO_TIMER_EVENT_MASK   = 7'h39;
  localparam logic [6:0] DATA_SPACE_OFFSET     = 7'h20;

  // ----------------------------------------------------------------
  // Field positions and reset values
  // ----------------------------------------------------------------
  localparam int CAPTURE_BIT   = 5;
  localparam int COMPARE_A_BIT = 4;
  localparam int COMPARE_B_BIT = 3;
  localparam int OVERFLOW_BIT  = 2;
  localparam logic [7:0] OWNED_BITS_MASK = 8'h3c;
  localparam logic [7:0] RESET_VALUE     = 8'h00;

  // ----------------------------------------------------------------
  // Waveform modes
  // ----------------------------------------------------------------
  localparam logic [3:0] MODE_NORMAL       = 4'h0;
  localparam logic [3:0] MODE_CTC_COMPARE  = 4'h4;
  localparam logic [3:0] MODE_CTC_CAPTURE  = 4'hc;
  localparam logic [3:0] MODE_FAST_CAPTURE = 4'he;
  localparam logic [3:0] MODE_PHASE_CAP_A  = 4'h8;
  localparam logic [3:0] MODE_PHASE_CAP_B  = 4'ha;

endpackage : tef_pkg

// ==== tef_timer_event_flags.sv ====
`timescale 1ns/1ns
// Functional notes
// - Capture high byte register, 8-bit RW, reset zero, I/O offset 0x27.
// - Registers answer at I/O offset, or offset plus 0x20 in data space.
// - Capture enable bit 5 gates capture flag, only with global enable.
// - Compare-A enable bit 4 gates compare-A flag with global enable.
// - Compare-B enable bit 3 gates compare-B flag with global enable.
// - Overflow enable bit 2 gates overflow flag with global enable.
// - Capture flag bit 5 sets on a capture pin event.
// - With capture value as top, capture flag sets at top instead.
// - Flags clear on vector execution or writing one; zero leaves unchanged.
// - Compare-A flag bit 4 sets the cycle after counter equals compare A.
// - Force compare A never sets compare-A flag.
// - Compare-B flag bit 3 sets the cycle after counter equals compare B.
// - Force compare B never sets compare-B flag.
// - Overflow flag bit 2 sets on overflow in normal and CTC modes.
// - Bits 7, 6, 1, 0 belong to other timers; never driven here.
// - Capture reads pass through a shared high-byte latch for coherence.
module tef_timer_event_flags (
  input  wire logic       clk_i,              // I/O clock
  input  wire logic       rst_i,              // Synchronous reset, active high
  input  wire logic [6:0] io_addr_i,          // I/O offset or data-space address
  input  wire logic       io_space_i,         // 1: I/O instruction, 0: load/store
  input  wire logic       io_wr_i,            // Write strobe
  input  wire logic       io_rd_i,            // Read strobe
  input  wire logic [7:0] io_wdata_i,         // Write data
  output logic      [7:0] io_rdata_o,         // Read data, owned bits only for flags and mask
  output logic            io_hit_o,           // Address decoded by this block
  input  wire logic       global_irq_en_i,    // Global interrupt enable
  input  wire logic [3:0] waveform_mode_select_i, // Waveform mode
  input  wire logic       capture_evt_i,      // Capture pin event pulse
  input  wire logic       top_evt_i,          // Counter reached top pulse
  input  wire logic       match_a_i,          // Counter equals compare A pulse
  input  wire logic       match_b_i,          // Counter equals compare B pulse
  input  wire logic       force_compare_a_i,  // Force strobe A
  input  wire logic       force_compare_b_i,  // Force strobe B
  input  wire logic       overflow_evt_i,     // Counter overflow pulse
  input  wire logic       mode_tov_evt_i,     // Mode-specific overflow point pulse
  input  wire logic       capture_load_i,     // Load new capture value
  input  wire logic [15:0] capture_sample_i,  // Counter value to capture
  input  wire logic       low_byte_rd_i,      // Low byte read, loads shared latch
  input  wire logic [7:0] shared_temp_i,      // Shared high-byte latch value
  input  wire logic [3:0] vector_ack_i,       // Vector executed: cap, a, b, ovf
  output logic      [3:0] irq_req_o,          // Requests: cap, a, b, ovf
  output logic      [7:0] capture_value_low_o, // Captured low byte
  output logic      [7:0] temp_load_o         // High byte for shared latch
);

  // ----------------------------------------------------------------
  // State
  // ----------------------------------------------------------------
  typedef struct packed {
    logic [7:0] cap_high;
    logic [7:0] cap_low;
    logic [7:0] flags;
    logic [7:0] mask;
    logic       match_a_d;
    logic       match_b_d;
  } tef_state_t;

  tef_state_t st_r;
  tef_state_t st_nxt;

  // Maps both address spaces onto one I/O offset
  function automatic logic [6:0] tef_io_offset(input logic [6:0] a, input logic io);
    tef_io_offset = io ? a : 7'(a - tef_pkg::DATA_SPACE_OFFSET);
  endfunction : tef_io_offset

  logic [6:0] off;
  logic       sel_cap;
  logic       sel_flg;
  logic       sel_msk;
  logic       cap_top_mode;
  logic       tov_std_mode;
  logic [3:0] ev;
  logic [3:0] clr;

  // ----------------------------------------------------------------
  // Address decode
  // ----------------------------------------------------------------
  always_comb begin
    off     = tef_io_offset(io_addr_i, io_space_i);
    sel_cap = 1'b0;
    sel_flg = 1'b0;
    sel_msk = 1'b0;
    // Data space below 0x20 wraps to a high offset and misses every register
    if (off == tef_pkg::IO_CAPTURE_VALUE_HIGH) begin
      sel_cap = 1'b1;
    end else if (off == tef_pkg::IO_TIMER_EVENT_FLAGS) begin
      sel_flg = 1'b1;
    end else if (off == tef_pkg::IO_TIMER_EVENT_MASK) begin
      sel_msk = 1'b1;
    end
  end

  // Capture sets at top only in modes where the capture value is top
  assign cap_top_mode = (waveform_mode_select_i == tef_pkg::MODE_CTC_CAPTURE)
                     || (waveform_mode_select_i == tef_pkg::MODE_FAST_CAPTURE)
                     || (waveform_mode_select_i == tef_pkg::MODE_PHASE_CAP_A)
                     || (waveform_mode_select_i == tef_pkg::MODE_PHASE_CAP_B);
  assign tov_std_mode = (waveform_mode_select_i == tef_pkg::MODE_NORMAL)
                     || (waveform_mode_select_i == tef_pkg::MODE_CTC_COMPARE)
                     || (waveform_mode_select_i == tef_pkg::MODE_CTC_CAPTURE);

  // ----------------------------------------------------------------
  // Next state
  // ----------------------------------------------------------------
  always_comb begin
    st_nxt = st_r;
    // Match is delayed one cycle; force strobes are never looked at
    st_nxt.match_a_d = match_a_i;
    st_nxt.match_b_d = match_b_i;
    ev[3] = cap_top_mode ? top_evt_i : capture_evt_i;
    ev[2] = st_r.match_a_d;
    ev[1] = st_r.match_b_d;
    ev[0] = tov_std_mode ? overflow_evt_i : mode_tov_evt_i;
    clr = vector_ack_i;
    if (io_wr_i && sel_flg) begin
      clr = clr | {io_wdata_i[tef_pkg::CAPTURE_BIT], io_wdata_i[tef_pkg::COMPARE_A_BIT],
                   io_wdata_i[tef_pkg::COMPARE_B_BIT], io_wdata_i[tef_pkg::OVERFLOW_BIT]};
    end
    // Set beats clear so an event in the clearing cycle survives
    st_nxt.flags[tef_pkg::CAPTURE_BIT]   = ev[3] | (st_r.flags[tef_pkg::CAPTURE_BIT] & ~clr[3]);
    st_nxt.flags[tef_pkg::COMPARE_A_BIT] = ev[2] | (st_r.flags[tef_pkg::COMPARE_A_BIT] & ~clr[2]);
    st_nxt.flags[tef_pkg::COMPARE_B_BIT] = ev[1] | (st_r.flags[tef_pkg::COMPARE_B_BIT] & ~clr[1]);
    st_nxt.flags[tef_pkg::OVERFLOW_BIT]  = ev[0] | (st_r.flags[tef_pkg::OVERFLOW_BIT] & ~clr[0]);
    if (io_wr_i && sel_msk) begin
      st_nxt.mask = io_wdata_i & tef_pkg::OWNED_BITS_MASK;
    end
    // Capture load from the counter; CPU write of high byte also lands here
    if (capture_load_i && !cap_top_mode) begin
      st_nxt.cap_high = capture_sample_i[15:8];
      st_nxt.cap_low  = capture_sample_i[7:0];
    end else if (io_wr_i && sel_cap) begin
      st_nxt.cap_high = io_wdata_i;
    end
    if (rst_i) begin
      st_nxt = '0;
    end
  end

  always_ff @(posedge clk_i) begin
    st_r <= st_nxt;
  end

  // ----------------------------------------------------------------
  // Outputs
  // ----------------------------------------------------------------
  // Request needs flag, its enable, and the global enable
  assign irq_req_o[3] = global_irq_en_i & st_r.mask[tef_pkg::CAPTURE_BIT]
                      & st_r.flags[tef_pkg::CAPTURE_BIT];
  assign irq_req_o[2] = global_irq_en_i & st_r.mask[tef_pkg::COMPARE_A_BIT]
                      & st_r.flags[tef_pkg::COMPARE_A_BIT];
  assign irq_req_o[1] = global_irq_en_i & st_r.mask[tef_pkg::COMPARE_B_BIT]
                      & st_r.flags[tef_pkg::COMPARE_B_BIT];
  assign irq_req_o[0] = global_irq_en_i & st_r.mask[tef_pkg::OVERFLOW_BIT]
                      & st_r.flags[tef_pkg::OVERFLOW_BIT];

  // Reads of the high byte come from the shared latch, not the live register
  always_comb begin
    io_rdata_o = 8'h00;
    io_hit_o   = sel_cap | sel_flg | sel_msk;
    if (sel_cap) begin
      io_rdata_o = shared_temp_i;
    end else if (sel_flg) begin
      io_rdata_o = st_r.flags & tef_pkg::OWNED_BITS_MASK;
    end else if (sel_msk) begin
      io_rdata_o = st_r.mask & tef_pkg::OWNED_BITS_MASK;
    end
  end

  assign capture_value_low_o = st_r.cap_low;
  assign temp_load_o         = st_r.cap_high;

  // ----------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------
  a_match_a_delay: assert property (@(posedge clk_i) disable iff (rst_i)
    match_a_i ##1 1'b1 |=> st_r.flags[tef_pkg::COMPARE_A_BIT])
    else $error("compare A flag not set after match");
  a_match_b_delay: assert property (@(posedge clk_i) disable iff (rst_i)
    match_b_i |=> ##1 st_r.flags[tef_pkg::COMPARE_B_BIT])
    else $error("compare B flag not set after match");
  a_force_a_quiet: assert property (@(posedge clk_i) disable iff (rst_i)
    (force_compare_a_i && !match_a_i && !st_r.match_a_d && !st_r.flags[tef_pkg::COMPARE_A_BIT])
    |=> !st_r.flags[tef_pkg::COMPARE_A_BIT])
    else $error("force strobe A set the flag");
  a_force_b_quiet: assert property (@(posedge clk_i) disable iff (rst_i)
    (force_compare_b_i && !st_r.match_b_d && !st_r.flags[tef_pkg::COMPARE_B_BIT])
    |=> !st_r.flags[tef_pkg::COMPARE_B_BIT])
    else $error("force strobe B set the flag");
  a_capture_set: assert property (@(posedge clk_i) disable iff (rst_i)
    (capture_evt_i && !cap_top_mode) |=> st_r.flags[tef_pkg::CAPTURE_BIT])
    else $error("capture event lost");
  a_capture_top: assert property (@(posedge clk_i) disable iff (rst_i)
    (top_evt_i && cap_top_mode) |=> st_r.flags[tef_pkg::CAPTURE_BIT])
    else $error("capture flag not set at top");
  a_overflow_set: assert property (@(posedge clk_i) disable iff (rst_i)
    (overflow_evt_i && tov_std_mode) |=> st_r.flags[tef_pkg::OVERFLOW_BIT])
    else $error("overflow flag not set");
  a_write_zero_keeps: assert property (@(posedge clk_i) disable iff (rst_i)
    (io_wr_i && sel_flg && (io_wdata_i & tef_pkg::OWNED_BITS_MASK) == 8'h00 && vector_ack_i == 4'h0)
    |=> (st_r.flags & $past(st_r.flags)) == $past(st_r.flags))
    else $error("write of zero cleared a flag");
  a_write_one_clears: assert property (@(posedge clk_i) disable iff (rst_i)
    (io_wr_i && sel_flg && io_wdata_i[tef_pkg::OVERFLOW_BIT] && !ev[0]) |=> !st_r.flags[tef_pkg::OVERFLOW_BIT])
    else $error("write of one did not clear overflow flag");
  a_irq_gate: assert property (@(posedge clk_i) disable iff (rst_i)
    (capture_evt_i && !cap_top_mode && global_irq_en_i && st_r.mask[tef_pkg::CAPTURE_BIT] && !(io_wr_i && sel_msk))
    ##1 global_irq_en_i |-> irq_req_o[3])
    else $error("capture event raised no request");
  // The high byte read is a full data byte; only flag and mask reads are trimmed
  a_foreign_bits: assert property (@(posedge clk_i) disable iff (rst_i)
    ((st_r.mask | st_r.flags) & ~tef_pkg::OWNED_BITS_MASK) == 8'h00
    && (sel_cap || (io_rdata_o & ~tef_pkg::OWNED_BITS_MASK) == 8'h00))
    else $error("foreign bits touched");

  // ----------------------------------------------------------------
  // Reset and register access checks
  // ----------------------------------------------------------------
  // Everything comes out of reset at zero, whatever the event pulses were doing
  a_reset_zero: assert property (@(posedge clk_i)
    rst_i |=> st_r.flags == 8'h00 && st_r.mask == 8'h00 && temp_load_o == 8'h00
              && capture_value_low_o == 8'h00 && irq_req_o == 4'h0)
    else $error("state not zero after reset");
  // The same register answers at its I/O offset and 0x20 higher in data space
  a_io_space_read: assert property (@(posedge clk_i) disable iff (rst_i)
    (io_space_i && io_addr_i == tef_pkg::IO_TIMER_EVENT_FLAGS)
    |-> io_hit_o && io_rdata_o == (st_r.flags & tef_pkg::OWNED_BITS_MASK))
    else $error("flag register missed in I/O space");
  a_data_space_read: assert property (@(posedge clk_i) disable iff (rst_i)
    (!io_space_i && io_addr_i == 7'(tef_pkg::IO_TIMER_EVENT_MASK + tef_pkg::DATA_SPACE_OFFSET))
    |-> io_hit_o && io_rdata_o == st_r.mask)
    else $error("mask register missed in data space");
  // Unmapped addresses read as zero so the core can OR the read buses of all blocks
  a_unmapped_quiet: assert property (@(posedge clk_i) disable iff (rst_i)
    !io_hit_o |-> io_rdata_o == 8'h00)
    else $error("unmapped address drove read data");
  // A CPU write of the high byte lands unless a capture load claims the cycle
  a_cap_write: assert property (@(posedge clk_i) disable iff (rst_i)
    (io_wr_i && sel_cap && !(capture_load_i && !cap_top_mode)) |=> temp_load_o == $past(io_wdata_i))
    else $error("capture high byte write lost");
  // Both bytes of a sample move together; a torn sample would defeat the shared latch
  a_cap_load: assert property (@(posedge clk_i) disable iff (rst_i)
    (capture_load_i && !cap_top_mode) |=> {temp_load_o, capture_value_low_o} == $past(capture_sample_i))
    else $error("capture sample torn");
  // Capture bytes hold between loads and writes
  a_cap_hold: assert property (@(posedge clk_i) disable iff (rst_i)
    !(capture_load_i && !cap_top_mode) && !(io_wr_i && sel_cap)
    |=> $stable(temp_load_o) && $stable(capture_value_low_o))
    else $error("capture bytes changed on their own");
  // Mask writes keep only the enables owned here
  a_mask_write: assert property (@(posedge clk_i) disable iff (rst_i)
    (io_wr_i && sel_msk) |=> st_r.mask == ($past(io_wdata_i) & tef_pkg::OWNED_BITS_MASK))
    else $error("mask write lost");
  a_mask_hold: assert property (@(posedge clk_i) disable iff (rst_i)
    !(io_wr_i && sel_msk) |=> $stable(st_r.mask))
    else $error("mask changed without a write");

  // ----------------------------------------------------------------
  // Flag setting, clearing and request gating checks
  // ----------------------------------------------------------------
  // A vector clears its own flag unless a fresh event lands in the same cycle
  a_vector_clr_cap: assert property (@(posedge clk_i) disable iff (rst_i)
    (vector_ack_i[3] && !ev[3]) |=> !st_r.flags[tef_pkg::CAPTURE_BIT])
    else $error("capture vector did not clear its flag");
  a_vector_clr_a: assert property (@(posedge clk_i) disable iff (rst_i)
    (vector_ack_i[2] && !ev[2]) |=> !st_r.flags[tef_pkg::COMPARE_A_BIT])
    else $error("compare A vector did not clear its flag");
  a_vector_clr_b: assert property (@(posedge clk_i) disable iff (rst_i)
    (vector_ack_i[1] && !ev[1]) |=> !st_r.flags[tef_pkg::COMPARE_B_BIT])
    else $error("compare B vector did not clear its flag");
  a_vector_clr_ovf: assert property (@(posedge clk_i) disable iff (rst_i)
    (vector_ack_i[0] && !ev[0]) |=> !st_r.flags[tef_pkg::OVERFLOW_BIT])
    else $error("overflow vector did not clear its flag");
  // Set beats clear; a lost event here would be a lost interrupt
  a_set_beats_clr: assert property (@(posedge clk_i) disable iff (rst_i)
    (vector_ack_i[2] && ev[2]) |=> st_r.flags[tef_pkg::COMPARE_A_BIT])
    else $error("clear won over a compare A event");
  // Outside the standard modes the mode-specific point sets the overflow flag
  a_overflow_mode: assert property (@(posedge clk_i) disable iff (rst_i)
    (mode_tov_evt_i && !tov_std_mode) |=> st_r.flags[tef_pkg::OVERFLOW_BIT])
    else $error("mode overflow point lost");
  // Flags never rise without one of their own sources
  a_overflow_quiet: assert property (@(posedge clk_i) disable iff (rst_i)
    (!overflow_evt_i && !mode_tov_evt_i && !st_r.flags[tef_pkg::OVERFLOW_BIT]) |=> !st_r.flags[tef_pkg::OVERFLOW_BIT])
    else $error("overflow flag rose with no source");
  a_capture_quiet: assert property (@(posedge clk_i) disable iff (rst_i)
    (!capture_evt_i && !top_evt_i && !st_r.flags[tef_pkg::CAPTURE_BIT]) |=> !st_r.flags[tef_pkg::CAPTURE_BIT])
    else $error("capture flag rose with no source");
  a_compare_a_quiet: assert property (@(posedge clk_i) disable iff (rst_i)
    (!st_r.match_a_d && !st_r.flags[tef_pkg::COMPARE_A_BIT]) |=> !st_r.flags[tef_pkg::COMPARE_A_BIT])
    else $error("compare A flag rose with no match");
  a_compare_b_quiet: assert property (@(posedge clk_i) disable iff (rst_i)
    (!st_r.match_b_d && !st_r.flags[tef_pkg::COMPARE_B_BIT]) |=> !st_r.flags[tef_pkg::COMPARE_B_BIT])
    else $error("compare B flag rose with no match");
  // In capture-top modes a pin event alone must not set the capture flag
  a_capture_pin_ignored: assert property (@(posedge clk_i) disable iff (rst_i)
    (cap_top_mode && capture_evt_i && !top_evt_i && !st_r.flags[tef_pkg::CAPTURE_BIT])
    |=> !st_r.flags[tef_pkg::CAPTURE_BIT])
    else $error("pin event set capture flag in a top mode");
  // The global enable gates every request
  a_irq_global: assert property (@(posedge clk_i) disable iff (rst_i)
    !global_irq_en_i |-> irq_req_o == 4'h0)
    else $error("request without global enable");
  // A cleared enable bit silences its request even with the flag up
  a_irq_mask_b: assert property (@(posedge clk_i) disable iff (rst_i)
    !st_r.mask[tef_pkg::COMPARE_B_BIT] |-> !irq_req_o[1])
    else $error("compare B request while masked");
  a_irq_mask_ovf: assert property (@(posedge clk_i) disable iff (rst_i)
    !st_r.mask[tef_pkg::OVERFLOW_BIT] |-> !irq_req_o[0])
    else $error("overflow request while masked");

endmodule : tef_timer_event_flags
